// File: src/lcdr_cfg.svh
// Constants for the LCD reset defaults and command front end.
// Assumes inclusion by bare name from the design modules.
`ifndef LCDR_CFG_SVH
`define LCDR_CFG_SVH
// Command encodings
`define LCDR_CMD_DISP_HI 7'h57
`define LCDR_CMD_START_HI 2'h1
`define LCDR_CMD_PAGE_HI 4'hB
`define LCDR_CMD_SWRESET 8'hE2
// Reset defaults
`define LCDR_CONTRAST_RST 6'h20
`define LCDR_POWER_RST 3'h0
`define LCDR_STATIC_RST 2'h0
`define LCDR_START_RST 6'h00
`define LCDR_PAGE_RST 4'h0
`define LCDR_COLUMN_RST 8'h00
// Cycles the reset flag stays high after a reset command
`define LCDR_RST_BUSY_CYC 4'h4
// Serial byte length
`define LCDR_SER_BITS 4'h8
`endif

// File: src/lcdr_pkg.sv
// Types shared by the LCD command front end.
// Assumes lcdr_cfg.svh is on the include path.
`default_nettype none
package lcdr_pkg;
   // Bus transfer kinds
   typedef enum logic [3:0] {
      XFER_IDLE = 4'b0001,
      XFER_CMD = 4'b0010,
      XFER_DATA = 4'b0100,
      XFER_READ = 4'b1000
   } lcdr_xfer_type;
endpackage
`default_nettype wire

// File: src/lcdr_link_if.sv
// Carrier between the serial shifter and the command core.
// Assumes one clock shared by both ends.
`default_nettype none
interface lcdr_link_if;
   logic valid;
   logic [7:0] data;
   logic sel;
   modport src (output valid, output data, output sel);
   modport dst (input valid, input data, input sel);
endinterface
`default_nettype wire

// File: src/lcdr_serial.sv
// Serial input shifter, MSB first, eight bits to a byte.
// Assumes pins already synchronised by the top.
`include "lcdr_cfg.svh"
`default_nettype none
module lcdr_serial (
   input wire logic clk, // Core clock
   input wire logic rst_b, // Sync reset
   input wire logic ce, // Clock enable
   input wire logic sclk, // Synchronised serial clock
   input wire logic sdat, // Synchronised serial data
   input wire logic sel, // Synchronised command/data select
   input wire logic cs_b, // Synchronised chip select
   lcdr_link_if.src link // Byte out
);
   logic [7:0] shift;
   logic [3:0] count;
   logic sclk_d;
   logic byte_v;
   logic [7:0] byte_q;
   logic sel_q;
   wire rise = sclk & ~sclk_d & ~cs_b;
   wire last = (count == `LCDR_SER_BITS - 4'h1);
   wire [7:0] next_shift = {shift[6:0], sdat};
   // Shift MSB first; reset and deselect drop partial bytes
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shift <= 8'h00;
         count <= 4'h0;
         sclk_d <= 1'b0;
         byte_v <= 1'b0;
         byte_q <= 8'h00;
         sel_q <= 1'b0;
      end else if (ce) begin
         sclk_d <= sclk;
         byte_v <= rise & last;
         if (cs_b) begin
            count <= 4'h0;
         end else if (rise) begin
            shift <= next_shift;
            count <= last ? 4'h0 : count + 4'h1;
            if (last) begin
               byte_q <= next_shift;
               sel_q <= sel;
            end
         end
      end
   end
   assign link.valid = byte_v;
   assign link.data = byte_q;
   assign link.sel = sel_q;
endmodule
`default_nettype wire

// File: src/lcdr_core.sv
// Reset defaults and command decoder of the LCD driver front end.
// Assumes host pins arrive asynchronous and are synchronised here.
// Contract
// - Reset low returns every internal setting to its default.
// - Hardware reset: display off, normal display, segment direction normal.
// - Hardware reset clears the three-bit power control to zero.
// - Hardware reset clears partial serial input bits.
// - Hardware reset selects the first bias ratio.
// - Hardware reset clears all-points-on and leaves power save.
// - Any reset leaves read-modify-write mode.
// - Any reset clears the two-bit static indicator.
// - Any reset zeroes start line, column, page; scan direction normal.
// - Any reset cancels set modes, contrast to 100000, clears test.
// - Reset command applies only items 7 to 10 defaults.
// - In reset timing stops; row shift, inversion, static, blanking held high.
// - Transfers classified by select and strobes; internal timing only.
// - Serial bits shifted in most significant first.
// - Command 1010111x sets display on when bit zero is one.
// - Display off while all-points-on enters power save.
// - Command 01xxxxxx loads display start line.
// - Command 1011xxxx loads host page address.
// - Page load leaves status readback unchanged.
// - Status reports reset in progress for either reset source.
`include "lcdr_cfg.svh"
`default_nettype none
module lcdr_core #(
   parameter int TIMING_DIV = 16 // Core cycles per row shift pulse
) (
   input wire logic CORE_CLK, // 10 MHz core clock
   input wire logic RST_B, // Sync reset, active low
   input wire logic CE, // Clock enable
   input wire logic SERIAL_MODE, // 1 selects serial input
   input wire logic ENABLE_STYLE, // 1 selects enable-strobe style
   input wire logic CS_B, // Chip select, active low
   input wire logic COMMAND_DATA_SELECT, // 0 command, 1 data
   input wire logic RD_E, // Read strobe low, or enable high
   input wire logic WR_RW, // Write strobe low, or read/write level
   input wire logic [7:0] DATA_IN, // Parallel data bus
   input wire logic SER_CLK, // Serial clock
   input wire logic SER_DATA, // Serial data
   output logic [7:0] DATA_OUT, // Status read value
   output logic DATA_OE, // Drives data bus on status read
   output logic DISPLAY_ON, // Display enabled
   output logic DISPLAY_REVERSE, // Inverted display
   output logic SEG_REVERSE, // Segment direction bit
   output logic [2:0] POWER_CTRL, // Power control setting
   output logic BIAS_ALT, // 0 first bias ratio
   output logic ALL_ON, // Force all points on
   output logic POWER_SAVE, // Power saver active
   output logic RMW_MODE, // Read-modify-write active
   output logic [1:0] STATIC_IND, // Static indicator setting
   output logic [5:0] START_LINE, // Display start line
   output logic [7:0] COLUMN_ADDR, // Column address
   output logic [3:0] PAGE_ADDR, // Page address
   output logic ROW_REVERSE, // Row scan direction
   output logic RATIO_MODE, // Resistor ratio set pending
   output logic CONTRAST_MODE, // Contrast set pending
   output logic [5:0] CONTRAST, // Contrast value
   output logic TEST_MODE, // Test mode
   output logic RESETTING, // Reset in progress
   output logic ROW_SHIFT_PULSE_OUT, // Line clock
   output logic AC_INVERSION_OUT, // Frame inversion
   output logic STATIC_DRIVE_OUT, // Static drive
   output logic BLANKING_OUT_N // Blanking, low blanks
);
   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [6:0] sync1;
   logic [6:0] sync2;
   logic [7:0] data_s1;
   logic [7:0] data_s2;
   // Two flip-flops on every host bus and serial pin
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         sync1 <= 7'h7F;
         sync2 <= 7'h7F;
         data_s1 <= 8'h00;
         data_s2 <= 8'h00;
      end else if (CE) begin
         sync1 <= {CS_B, COMMAND_DATA_SELECT, RD_E, WR_RW, SER_CLK, SER_DATA, 1'b1};
         sync2 <= sync1;
         data_s1 <= DATA_IN;
         data_s2 <= data_s1;
      end
   end
   wire cs_b_s = sync2[6];
   wire sel_s = sync2[5];
   wire rde_s = sync2[4];
   wire wrrw_s = sync2[3];
   wire sclk_s = sync2[2];
   wire sdat_s = sync2[1];

   // ==========================================================
   // Parallel strobe decode
   // ==========================================================
   logic strobe_d;
   // Strobe is active-high in enable style, low-active write in separate style
   wire wr_act = ENABLE_STYLE ? (rde_s & ~wrrw_s) : ~wrrw_s;
   wire rd_act = ENABLE_STYLE ? (rde_s & wrrw_s) : ~rde_s;
   wire wr_end = strobe_d & ~wr_act & ~cs_b_s;
   always_ff @(posedge CORE_CLK) begin
      if (!RST_B) begin
         strobe_d <= 1'b0;
      end else if (CE) begin
         strobe_d <= wr_act & ~cs_b_s & ~SERIAL_MODE;
      end
   end

   // Byte from serial shifter
   lcdr_link_if ser_link();
   lcdr_serial u_serial (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .ce(CE & SERIAL_MODE),
      .sclk(sclk_s),
      .sdat(sdat_s),
      .sel(sel_s),
      .cs_b(cs_b_s),
      .link(ser_link)
   );

   // Classify the transfer
   lcdr_pkg::lcdr_xfer_type xfer;
   wire byte_v = SERIAL_MODE ? ser_link.valid : wr_end;
   wire byte_sel = SERIAL_MODE ? ser_link.sel : sel_s;
   wire [7:0] byte_d = SERIAL_MODE ? ser_link.data : data_s2;
   always_comb begin
      if (!byte_v) begin
         xfer = lcdr_pkg::XFER_IDLE;
      end else if (byte_sel) begin
         xfer = lcdr_pkg::XFER_DATA;
      end else begin
         xfer = lcdr_pkg::XFER_CMD;
      end
   end

   // ==========================================================
   // Command decode
   // ==========================================================
   wire is_cmd = (xfer == lcdr_pkg::XFER_CMD);
   wire cmd_disp = is_cmd & (byte_d[7:1] == `LCDR_CMD_DISP_HI);
   wire cmd_start = is_cmd & (byte_d[7:6] == `LCDR_CMD_START_HI);
   wire cmd_page = is_cmd & (byte_d[7:4] == `LCDR_CMD_PAGE_HI);
   wire cmd_swrst = is_cmd & (byte_d == `LCDR_CMD_SWRESET);
   wire hw_rst = !RST_B;

   // Hardware-only settings: untouched by the reset command
   always_ff @(posedge CORE_CLK) begin
      if (hw_rst) begin
         DISPLAY_ON <= 1'b0;
         DISPLAY_REVERSE <= 1'b0;
         SEG_REVERSE <= 1'b0;
         POWER_CTRL <= `LCDR_POWER_RST;
         BIAS_ALT <= 1'b0;
         ALL_ON <= 1'b0;
         POWER_SAVE <= 1'b0;
      end else if (CE && cmd_disp) begin
         DISPLAY_ON <= byte_d[0];
         POWER_SAVE <= ~byte_d[0] & ALL_ON;
      end
   end

   // Settings restored by either reset source
   always_ff @(posedge CORE_CLK) begin
      if (hw_rst || (CE && cmd_swrst)) begin
         RMW_MODE <= 1'b0;
         STATIC_IND <= `LCDR_STATIC_RST;
         START_LINE <= `LCDR_START_RST;
         COLUMN_ADDR <= `LCDR_COLUMN_RST;
         PAGE_ADDR <= `LCDR_PAGE_RST;
         ROW_REVERSE <= 1'b0;
         RATIO_MODE <= 1'b0;
         CONTRAST_MODE <= 1'b0;
         CONTRAST <= `LCDR_CONTRAST_RST;
         TEST_MODE <= 1'b0;
      end else if (CE) begin
         if (cmd_start) begin
            START_LINE <= byte_d[5:0];
         end
         if (cmd_page) begin
            PAGE_ADDR <= byte_d[3:0];
         end
      end
   end

   // Reset flag: held through hardware reset, short hold after command
   logic [3:0] busy_cnt;
   always_ff @(posedge CORE_CLK) begin
      if (hw_rst) begin
         busy_cnt <= `LCDR_RST_BUSY_CYC;
      end else if (CE) begin
         if (cmd_swrst) begin
            busy_cnt <= `LCDR_RST_BUSY_CYC;
         end else if (busy_cnt != 4'h0) begin
            busy_cnt <= busy_cnt - 4'h1;
         end
      end
   end
   assign RESETTING = (busy_cnt != 4'h0);

   // ==========================================================
   // Status readback
   // ==========================================================
   // Page is not part of status, so page loads leave it alone
   wire [7:0] next_status = {RESETTING, ~SEG_REVERSE, ~DISPLAY_ON, RESETTING, 4'h0};
   always_ff @(posedge CORE_CLK) begin
      if (hw_rst) begin
         DATA_OUT <= 8'h00;
         DATA_OE <= 1'b0;
      end else if (CE) begin
         DATA_OUT <= next_status;
         DATA_OE <= rd_act & ~cs_b_s & ~sel_s & ~SERIAL_MODE;
      end
   end

   // ==========================================================
   // Display timing generator
   // ==========================================================
   logic [15:0] tick;
   logic [5:0] line;
   wire tick_end = (tick == 16'(TIMING_DIV - 1));
   // Timing stops and drive outputs sit high in reset
   always_ff @(posedge CORE_CLK) begin
      if (hw_rst) begin
         tick <= 16'h0000;
         line <= 6'h00;
         ROW_SHIFT_PULSE_OUT <= 1'b1;
         AC_INVERSION_OUT <= 1'b1;
         STATIC_DRIVE_OUT <= 1'b1;
         BLANKING_OUT_N <= 1'b1;
      end else if (CE) begin
         tick <= tick_end ? 16'h0000 : tick + 16'h0001;
         ROW_SHIFT_PULSE_OUT <= tick_end;
         BLANKING_OUT_N <= DISPLAY_ON;
         STATIC_DRIVE_OUT <= ~(STATIC_IND != 2'h0);
         if (tick_end) begin
            line <= line + 6'h01;
            if (line == 6'h3F) begin
               AC_INVERSION_OUT <= ~AC_INVERSION_OUT;
            end
         end
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   // Command effects, one cycle after the byte is taken
   a_disp_on_cmd: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && cmd_disp && !cmd_swrst) |=> (DISPLAY_ON == $past(byte_d[0])))
      else $error("display bit not taken from command");
   a_save_entry: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && cmd_disp && !byte_d[0] && ALL_ON) |=> POWER_SAVE)
      else $error("power save not entered");
   a_start_load: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && cmd_start) |=> (START_LINE == $past(byte_d[5:0])))
      else $error("start line not loaded");
   a_page_load: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && cmd_page) |=> (PAGE_ADDR == $past(byte_d[3:0])))
      else $error("page not loaded");
   a_page_status: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && cmd_page) |=> (DATA_OUT[3:0] == 4'h0 && $stable(SEG_REVERSE)
      && $stable(DISPLAY_ON)))
      else $error("page load touched status");
   a_unknown_keep: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && is_cmd && !cmd_disp && !cmd_start && !cmd_page && !cmd_swrst)
      |=> ($stable(START_LINE) && $stable(PAGE_ADDR) && $stable(DISPLAY_ON)))
      else $error("unknown command changed a setting");
   a_data_ignored: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && xfer == lcdr_pkg::XFER_DATA)
      |=> ($stable(START_LINE) && $stable(PAGE_ADDR) && $stable(DISPLAY_ON)))
      else $error("data byte taken as command");

   // Reset command: soft defaults applied, hardware-only settings kept
   a_swrst_keep: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && cmd_swrst) |=> ($stable(DISPLAY_ON) && CONTRAST == 6'h20 && RESETTING))
      else $error("reset command defaults wrong");
   a_swrst_hold: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && cmd_swrst) |=> ($stable(POWER_CTRL) && $stable(BIAS_ALT) && $stable(SEG_REVERSE)))
      else $error("reset command changed hardware-only setting");
   a_swrst_addr: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && cmd_swrst) |=> (START_LINE == 6'h00 && PAGE_ADDR == 4'h0 && COLUMN_ADDR == 8'h00))
      else $error("reset command left an address");

   // Hardware reset defaults and held pins
   a_hw_defaults: assert property (
      @(posedge CORE_CLK)
      !RST_B |=> (!DISPLAY_ON && POWER_CTRL == 3'h0 && !ALL_ON && RESETTING))
      else $error("hardware defaults wrong");
   a_hw_soft: assert property (
      @(posedge CORE_CLK)
      !RST_B |=> (STATIC_IND == 2'h0 && !RMW_MODE && START_LINE == 6'h00 && PAGE_ADDR == 4'h0))
      else $error("hardware reset left a soft setting");
   a_rst_pins: assert property (
      @(posedge CORE_CLK)
      !RST_B |=> (ROW_SHIFT_PULSE_OUT && AC_INVERSION_OUT && BLANKING_OUT_N))
      else $error("drive pins not high in reset");

   // Reset flag reaches status and ends on time
   a_busy_status: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && RESETTING) |=> DATA_OUT[7])
      else $error("reset flag missing from status");
   a_busy_ends: assert property (
      @(posedge CORE_CLK) disable iff (!RST_B)
      (CE && cmd_swrst) ##1 (CE && !cmd_swrst) [*4] |=> !RESETTING)
      else $error("reset flag stuck");
endmodule
`default_nettype wire

// File: tb/lcdr_host.sv
// Host model driving the pins of the LCD command front end.
// Assumes the bench calls its tasks; pins change only after clk rises.
`default_nettype none
module lcdr_host (
   input wire logic clk, // Core clock
   input wire logic en_style, // 1 enable strobe style
   input wire logic [7:0] q_in, // Status from core
   input wire logic oe_in, // Core drives bus
   output logic cs_b, // Chip select
   output logic sel, // Command/data select
   output logic rd_e, // Read strobe or enable
   output logic wr_rw, // Write strobe or read/write
   output logic [7:0] dq, // Parallel data
   output logic sclk, // Serial clock, still between frames
   output logic sdat // Serial data
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Pin drive
   initial begin
      cs_b = 1'b1;
      sel = 1'b0;
      rd_e = 1'b1;
      wr_rw = 1'b1;
      dq = 8'h00;
      sclk = 1'b0;
      sdat = 1'b0;
   end
   // Released lines flip so no stale value looks valid
   task automatic idle();
      @(posedge clk);
      cs_b <= 1'b1;
      rd_e <= ~en_style;
      wr_rw <= 1'b1;
      dq <= ~dq;
      sdat <= ~sdat;
   endtask
   // One parallel transfer; strobe 5 cycles active, 5 released under select
   task automatic xfer(input logic rd, input logic a0, input logic [7:0] b,
                       output logic [7:0] q, output logic oe);
      @(posedge clk);
      cs_b <= 1'b0;
      sel <= a0;
      dq <= b;
      wr_rw <= en_style ? rd : 1'b1;
      @(posedge clk);
      if (en_style) rd_e <= 1'b1;
      else if (rd) rd_e <= 1'b0;
      else wr_rw <= 1'b0;
      repeat (5) @(posedge clk);
      q = q_in;
      oe = oe_in;
      rd_e <= ~en_style;
      wr_rw <= 1'b1;
      repeat (4) @(posedge clk);
      idle();
      repeat (4) @(posedge clk);
   endtask
   // Serial byte; a short byte leaves the frame open
   task automatic ser(input logic a0, input logic [7:0] b, input int n);
      @(posedge clk);
      cs_b <= 1'b0;
      sel <= a0;
      for (int i = 7; i > 7 - n; i--) begin
         sdat <= b[i];
         repeat (3) @(posedge clk);
         sclk <= 1'b1;
         repeat (3) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      if (n == 8) idle();
      repeat (4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the LCD reset defaults and command decoder.
// Assumes lcdr_core and lcdr_host are compiled before it.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ser_mode = 1'b0;
   logic en_style = 1'b0;
   logic [7:0] q;
   logic oe;
   int n_errors = 0;
   int n_checks = 0;
   int n_busy = 0;
   wire logic cs_b, sel, rd_e, wr_rw, sclk, sdat, doe, on, rev, segr, bias, allon, psave;
   wire logic rmw, rowr, ratio, cmode, test, busy, p_row, p_ac, p_stat, p_blank;
   wire logic [7:0] dq, dout, col;
   wire logic [2:0] pwr;
   wire logic [1:0] stat;
   wire logic [5:0] start, contrast;
   wire logic [3:0] page;
   wire logic [21:0] cfg = {on, rev, segr, pwr, bias, allon, psave, rmw, stat, rowr, ratio,
                            cmode, contrast, test};
   wire logic [17:0] adr = {start, col, page};
   // ==========
   // Clock, busy counter, parts
   always #50 clk = ~clk;
   always @(posedge clk) if (rst_b && busy === 1'b1) n_busy <= n_busy + 1;
   lcdr_core #(.TIMING_DIV(4)) lcdr_core_inst (
      .CORE_CLK(clk), .RST_B(rst_b), .CE(1'b1), .SERIAL_MODE(ser_mode),
      .ENABLE_STYLE(en_style), .CS_B(cs_b), .COMMAND_DATA_SELECT(sel), .RD_E(rd_e),
      .WR_RW(wr_rw), .DATA_IN(dq), .SER_CLK(sclk), .SER_DATA(sdat), .DATA_OUT(dout),
      .DATA_OE(doe), .DISPLAY_ON(on), .DISPLAY_REVERSE(rev), .SEG_REVERSE(segr),
      .POWER_CTRL(pwr), .BIAS_ALT(bias), .ALL_ON(allon), .POWER_SAVE(psave),
      .RMW_MODE(rmw), .STATIC_IND(stat), .START_LINE(start), .COLUMN_ADDR(col),
      .PAGE_ADDR(page), .ROW_REVERSE(rowr), .RATIO_MODE(ratio), .CONTRAST_MODE(cmode),
      .CONTRAST(contrast), .TEST_MODE(test), .RESETTING(busy), .ROW_SHIFT_PULSE_OUT(p_row),
      .AC_INVERSION_OUT(p_ac), .STATIC_DRIVE_OUT(p_stat), .BLANKING_OUT_N(p_blank));
   lcdr_host host_inst (
      .clk(clk), .en_style(en_style), .q_in(dout), .oe_in(doe), .cs_b(cs_b), .sel(sel),
      .rd_e(rd_e), .wr_rw(wr_rw), .dq(dq), .sclk(sclk), .sdat(sdat));
   // ==========
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Reset held 16 cycles; defaults and held pins looked at before release
   task automatic hw_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (16) @(posedge clk);
      chk("settings", 32'h0000_0040, 32'(cfg));
      chk("addresses", 32'h0000_0000, 32'(adr));
      chk("timing pins", 32'h0000_000F, 32'({p_row, p_ac, p_stat, p_blank}));
      chk("reset flag", 32'h0000_0001, 32'(busy));
      rst_b <= 1'b1;
      repeat (10) @(posedge clk);
      chk("reset flag", 32'h0000_0000, 32'(busy));
   endtask
   task automatic cmd(input logic a0, input logic [7:0] b);
      host_inst.xfer(1'b0, a0, b, q, oe);
      chk("bus drive on write", 32'h0000_0000, 32'(oe));
   endtask
   task automatic status(input logic [7:0] exp);
      host_inst.xfer(1'b1, 1'b0, 8'h00, q, oe);
      chk("status", 32'(exp), 32'(q));
      chk("bus drive", 32'h0000_0001, 32'(oe));
   endtask
   // ==========
   // Main sequence
   initial begin
      int n0;
      hw_reset();
      $display("test reset done");
      // Separate strobes: display on, status, address loads
      cmd(1'b0, 8'hAF);
      status(8'h40);
      cmd(1'b0, 8'h7F);
      cmd(1'b0, 8'hBF);
      chk("addresses", 32'h0003_F00F, 32'(adr));
      status(8'h40);
      cmd(1'b0, 8'hE3);
      cmd(1'b1, 8'hAE);
      chk("settings", 32'h0020_0040, 32'(cfg));
      chk("addresses", 32'h0003_F00F, 32'(adr));
      chk("blanking pin", 32'h0000_0001, 32'(p_blank));
      $display("test separate strobes done");
      // Enable strobe style
      @(posedge clk);
      en_style <= 1'b1;
      host_inst.idle();
      cmd(1'b0, 8'hAE);
      cmd(1'b0, 8'h6A);
      cmd(1'b0, 8'hB3);
      chk("addresses", 32'h0002_A003, 32'(adr));
      status(8'h60);
      chk("blanking pin", 32'h0000_0000, 32'(p_blank));
      $display("test enable strobe done");
      // Reset command keeps display state, clears addresses
      cmd(1'b0, 8'hAF);
      n0 = n_busy;
      cmd(1'b0, 8'hE2);
      repeat (8) @(posedge clk);
      chk("settings", 32'h0020_0040, 32'(cfg));
      chk("addresses", 32'h0000_0000, 32'(adr));
      chk("busy cycles", 32'h0000_0004, 32'(n_busy - n0));
      $display("test reset command done");
      // Serial bytes, then a broken byte cut short by reset
      @(posedge clk);
      ser_mode <= 1'b1;
      host_inst.ser(1'b0, 8'h4D, 8);
      host_inst.ser(1'b0, 8'hAF, 8);
      chk("addresses", 32'h0000_D000, 32'(adr));
      chk("settings", 32'h0020_0040, 32'(cfg));
      host_inst.ser(1'b0, 8'hFF, 4);
      hw_reset();
      host_inst.ser(1'b0, 8'hB5, 8);
      chk("addresses", 32'h0000_0005, 32'(adr));
      $display("test serial done");
      report_and_stop();
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
